// ==== design/upio_pkg.sv ====
// package: object indices, field layout, presets and timing for the user program i/o bank
package upio_pkg;

	// ----------------------------------------
	// object dictionary indices
	// ----------------------------------------
	localparam logic [15:0] IDX_UPTIME = 16'h230f;
	localparam logic [15:0] IDX_IN_SEL = 16'h2310;
	localparam logic [15:0] IDX_OUT_SEL = 16'h2320;
	localparam logic [15:0] IDX_INOUT_SEL = 16'h2330;
	localparam logic [15:0] IDX_INPUTS = 16'h2400;

	// ----------------------------------------
	// presets and counts
	// ----------------------------------------
	localparam logic [31:0] UPTIME_RESET = 32'h0000_0000;
	localparam logic [31:0] MAP_RESET = 32'h0000_0000;
	localparam logic [31:0] INPUT_RESET = 32'h0000_0000;
	localparam int SEL_ENTRIES = 16;
	localparam int INPUT_ENTRIES = 32;
	localparam logic [7:0] SEL_COUNT = 8'h10;
	localparam logic [7:0] INPUT_COUNT = 8'h20;

	// ----------------------------------------
	// mapping word fields
	// ----------------------------------------
	localparam int MAP_INDEX_MSB = 31;
	localparam int MAP_INDEX_LSB = 16;
	localparam int MAP_SUB_MSB = 15;
	localparam int MAP_SUB_LSB = 8;
	localparam int MAP_LEN_MSB = 7;
	localparam int MAP_LEN_LSB = 0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

	typedef struct packed {
		logic [15:0] index;
		logic [7:0] subindex;
		logic [7:0] length;
	} map_word_s;

	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_READ,
		ACC_WRITE
	} acc_e;

	// dictionary access from the process-data engine
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [7:0] subindex;
		logic [31:0] wdata;
	} od_req_s;

	typedef struct packed {
		logic valid;
		logic error;
		logic [31:0] rdata;
	} od_rsp_s;

endpackage : upio_pkg

// ==== design/user_program_io_mapping_objects.sv ====
// module: uptime counter, program i/o selection tables and fieldbus input words
`timescale 1ns/100ps

// Overview of operation
// RULE1: uptime counter advances once per elapsed second since controller start.
// RULE2: uptime is volatile and restarts from zero at every power-up.
// RULE3: uptime is unsigned 32-bit, preset zero, read-only, readable as process data.
// RULE4: before program run, copy each input-table entry into program input image.
// RULE5: after program run, copy program output image into each output-table entry.
// RULE6: in/out table entries copied in before and written back after run.
// RULE7: each table holds sixteen zero-preset read-only words; count reads 16.
// RULE8: mapping word bits 31..16 carry the dictionary index.
// RULE9: mapping word bits 15..8 carry the subindex.
// RULE10: mapping word bits 7..0 give the entry length in bits.
// RULE11: thirty-two signed 32-bit input words pass fieldbus values to the program.
// RULE12: input words are read/write, preset zero, mappable into receive data.
// RULE13: one-second tick comes from a clock prescaler; counter wraps to zero.
module user_program_io_mapping_objects
	import upio_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYCLES,
	parameter int N_SEL = SEL_ENTRIES,
	parameter int N_INPUTS = INPUT_ENTRIES
) (
	input wire logic mclk,
	input wire logic reset_n,
	// dictionary access from the fieldbus process-data engine
	input wire od_req_s od_req,
	output od_rsp_s od_rsp,
	// program run phases
	input wire logic pre_run,
	input wire logic post_run,
	output logic copy_in_busy,
	output logic copy_out_busy,
	// transfer of one mapped entry toward the program image / back
	output logic xfer_valid,
	output logic xfer_out,
	output map_word_s xfer_map,
	output logic [3:0] xfer_slot,
	input wire logic xfer_ready,
	output logic [31:0] uptime
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (N_SEL != 16 || N_INPUTS != 32 || TICK_COUNT < 1) begin : g_bad
		$error("unsupported parameter values");
	end

	function automatic logic is_table(input logic [15:0] idx);
		return idx == IDX_IN_SEL || idx == IDX_OUT_SEL || idx == IDX_INOUT_SEL;
	endfunction : is_table

	// ----------------------------------------
	// uptime
	// ----------------------------------------
	logic [31:0] presc;
	logic [31:0] next_presc;
	logic [31:0] next_uptime;

	always_comb begin
		next_presc = presc + 32'h0000_0001; // RULE13
		next_uptime = uptime;
		if (presc == 32'(TICK_COUNT - 1)) begin
			next_presc = 32'h0000_0000;
			next_uptime = uptime + 32'h0000_0001; // RULE1 RULE13
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			presc <= 32'h0000_0000;
			uptime <= UPTIME_RESET; // RULE2
		end else begin
			presc <= next_presc;
			uptime <= next_uptime;
		end
	end

	// ----------------------------------------
	// selection tables and input words
	// ----------------------------------------
	// tables are read-only to the host and hold their preset; loading is firmware's job
	logic [31:0] sel_tab [3][SEL_ENTRIES];
	logic [31:0] inputs [INPUT_ENTRIES];
	logic [31:0] next_inputs [INPUT_ENTRIES];

	always_comb begin
		for (int t = 0; t < 3; t++) begin
			for (int i = 0; i < SEL_ENTRIES; i++) begin
				sel_tab[t][i] = MAP_RESET; // RULE7
			end
		end
	end

	always_comb begin
		for (int i = 0; i < INPUT_ENTRIES; i++) begin
			next_inputs[i] = inputs[i];
		end
		if (od_req.valid && od_req.write && od_req.index == IDX_INPUTS
				&& od_req.subindex >= 8'h01 && od_req.subindex <= INPUT_COUNT) begin
			next_inputs[5'(od_req.subindex - 8'h01)] = od_req.wdata; // RULE11 RULE12
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < INPUT_ENTRIES; i++) begin
			if (!reset_n) begin
				inputs[i] <= INPUT_RESET; // RULE12
			end else begin
				inputs[i] <= next_inputs[i];
			end
		end
	end

	// ----------------------------------------
	// dictionary read / write answer
	// ----------------------------------------
	od_rsp_s next_rsp;
	logic [3:0] sub_slot;

	always_comb begin
		next_rsp = '0;
		sub_slot = 4'(od_req.subindex - 8'h01);
		if (od_req.valid) begin
			next_rsp.valid = 1'b1;
			if (od_req.index == IDX_UPTIME && od_req.subindex == 8'h00) begin
				next_rsp.error = od_req.write; // RULE3
				next_rsp.rdata = uptime; // RULE3
			end else if (is_table(od_req.index)) begin
				if (od_req.write) begin
					next_rsp.error = 1'b1; // RULE7
				end else if (od_req.subindex == 8'h00) begin
					next_rsp.rdata = {24'h00_0000, SEL_COUNT}; // RULE7
				end else if (od_req.subindex <= SEL_COUNT) begin
					case (od_req.index)
						IDX_IN_SEL: next_rsp.rdata = sel_tab[0][sub_slot];
						IDX_OUT_SEL: next_rsp.rdata = sel_tab[1][sub_slot];
						default: next_rsp.rdata = sel_tab[2][sub_slot];
					endcase
				end else begin
					next_rsp.error = 1'b1;
				end
			end else if (od_req.index == IDX_INPUTS) begin
				if (od_req.subindex == 8'h00) begin
					next_rsp.error = od_req.write;
					next_rsp.rdata = {24'h00_0000, INPUT_COUNT};
				end else if (od_req.subindex <= INPUT_COUNT) begin
					next_rsp.rdata = od_req.write ? 32'h0000_0000
						: inputs[5'(od_req.subindex - 8'h01)]; // RULE12
				end else begin
					next_rsp.error = 1'b1;
				end
			end else begin
				next_rsp.error = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			od_rsp <= '0;
		end else begin
			od_rsp <= next_rsp;
		end
	end

	// ----------------------------------------
	// copy sequencer
	// ----------------------------------------
	// walks the input table then the in/out table before a run,
	// and the output table then the in/out table after it
	typedef enum {
		SEQ_IDLE,
		SEQ_IN,
		SEQ_IO_IN,
		SEQ_OUT,
		SEQ_IO_OUT
	} seq_e;

	seq_e state;
	seq_e next_state;
	logic [3:0] slot;
	logic [3:0] next_slot;
	map_word_s cur_map;

	always_comb begin
		case (state)
			SEQ_IN: cur_map = sel_tab[0][slot];
			SEQ_OUT: cur_map = sel_tab[1][slot];
			SEQ_IO_IN, SEQ_IO_OUT: cur_map = sel_tab[2][slot];
			default: cur_map = '0;
		endcase
	end

	always_comb begin
		next_state = state;
		next_slot = slot;
		case (state)
			SEQ_IDLE: begin
				next_slot = 4'h0;
				if (pre_run) begin
					next_state = SEQ_IN; // RULE4
				end else if (post_run) begin
					next_state = SEQ_OUT; // RULE5
				end
			end
			SEQ_IN, SEQ_IO_IN, SEQ_OUT, SEQ_IO_OUT: begin
				if (xfer_ready) begin
					next_slot = slot + 4'h1;
					if (slot == 4'hf) begin
						case (state)
							SEQ_IN: next_state = SEQ_IO_IN; // RULE6
							SEQ_OUT: next_state = SEQ_IO_OUT; // RULE6
							default: next_state = SEQ_IDLE;
						endcase
					end
				end
			end
			default: next_state = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state <= SEQ_IDLE;
			slot <= 4'h0;
		end else begin
			state <= next_state;
			slot <= next_slot;
		end
	end

	// unused slots (index zero) are still presented; the consumer takes and counts them like any other
	assign xfer_valid = state != SEQ_IDLE;
	assign xfer_out = state == SEQ_OUT || state == SEQ_IO_OUT; // RULE5
	assign xfer_map.index = cur_map.index; // RULE8
	assign xfer_map.subindex = cur_map.subindex; // RULE9
	assign xfer_map.length = cur_map.length; // RULE10
	assign xfer_slot = slot;
	assign copy_in_busy = state == SEQ_IN || state == SEQ_IO_IN; // RULE4
	assign copy_out_busy = xfer_out;

endmodule : user_program_io_mapping_objects

// ==== sim/upio_chk.sv ====
// checker: port properties of the i/o bank
`timescale 1ns/100ps
module upio_chk
	import upio_pkg::*;
#(parameter int TICK_COUNT = 10) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire od_req_s od_req,
	input wire od_rsp_s od_rsp,
	input wire logic pre_run,
	input wire logic post_run,
	input wire logic copy_in_busy,
	input wire logic copy_out_busy,
	input wire logic xfer_valid,
	input wire logic xfer_out,
	input wire map_word_s xfer_map,
	input wire logic [3:0] xfer_slot,
	input wire logic xfer_ready,
	input wire logic [31:0] uptime
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic idle;
	assign idle = !copy_in_busy && !copy_out_busy;
	a_rsp_next: assert property (od_req.valid |=> od_rsp.valid) else $error("no answer");
	a_rsp_quiet: assert property (!od_req.valid |=> !od_rsp.valid) else $error("stray answer");
	a_uptime_ro: assert property (od_req.valid && od_req.write && od_req.index == IDX_UPTIME
		|=> od_rsp.error) else $error("uptime written");
	a_map_zero: assert property (xfer_valid |-> xfer_map == MAP_RESET) else $error("map word");
	a_pre_start: assert property (pre_run && idle |=> xfer_valid && !xfer_out && xfer_slot == 0)
		else $error("copy-in start");
	a_post_start: assert property (post_run && !pre_run && idle |=> xfer_valid && xfer_out)
		else $error("copy-out start");
	a_slot_hold: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_slot))
		else $error("slot moved");
	a_uptime_step: assert property (uptime != $past(uptime) |-> uptime == $past(uptime) + 1)
		else $error("uptime step");
	a_uptime_zero: assert property (disable iff (1'b0) !reset_n |=> uptime == UPTIME_RESET)
		else $error("uptime preset");
	c_copy_in: cover property (pre_run && idle);
	c_copy_out: cover property (post_run && idle);
	c_stall: cover property (xfer_valid && !xfer_ready);
endmodule : upio_chk
bind user_program_io_mapping_objects upio_chk #(.TICK_COUNT(TICK_COUNT)) u_upio_chk (
	.mclk(mclk), .reset_n(reset_n), .od_req(od_req), .od_rsp(od_rsp), .pre_run(pre_run),
	.post_run(post_run), .copy_in_busy(copy_in_busy), .copy_out_busy(copy_out_busy),
	.xfer_valid(xfer_valid), .xfer_out(xfer_out), .xfer_map(xfer_map), .xfer_slot(xfer_slot),
	.xfer_ready(xfer_ready), .uptime(uptime));

// ==== sim/upio_consumer.sv ====
// partner: program-side taker of mapping words
`timescale 1ns/100ps
module upio_consumer (
	input wire logic mclk,
	input wire logic xfer_valid,
	input wire logic xfer_out,
	input wire logic slow,
	output logic xfer_ready,
	output int n_in,
	output int n_out
);
	logic ph = 1'b0;
	initial begin
		xfer_ready = 1'b0;
		n_in = 0;
		n_out = 0;
	end
	// slow mode accepts every other cycle to stall the sequencer
	always @(negedge mclk) begin
		ph <= !ph;
		xfer_ready <= xfer_valid && (!slow || ph);
	end
	always @(posedge mclk) begin
		if (xfer_valid && xfer_ready) begin
			if (xfer_out) n_out <= n_out + 1;
			else n_in <= n_in + 1;
		end
	end
endmodule : upio_consumer

// ==== sim/user_program_io_mapping_objects_test.sv ====
// testbench: dictionary access, program copy phases and uptime
`timescale 1ns/100ps
module user_program_io_mapping_objects_test
	import upio_pkg::*;
;
	logic mclk, reset_n, pre_run, post_run, cib, cob, xv, xo, xr, slow, er;
	od_req_s od_req;
	od_rsp_s od_rsp;
	map_word_s xm;
	logic [3:0] xs;
	logic [31:0] up, rv;
	int n_in, n_out, n_mismatch = 0, num_checks = 0, cyc = 0, i;
	user_program_io_mapping_objects #(.TICK_COUNT(10)) u_user_program_io_mapping_objects (
		.mclk(mclk), .reset_n(reset_n), .od_req(od_req), .od_rsp(od_rsp), .pre_run(pre_run),
		.post_run(post_run), .copy_in_busy(cib), .copy_out_busy(cob), .xfer_valid(xv),
		.xfer_out(xo), .xfer_map(xm), .xfer_slot(xs), .xfer_ready(xr), .uptime(up));
	upio_consumer u_upio_consumer (.mclk(mclk), .xfer_valid(xv), .xfer_out(xo), .slow(slow),
		.xfer_ready(xr), .n_in(n_in), .n_out(n_out));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task results;
		if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d);
		@(negedge mclk);
		od_req = '{1'b1, w, ix, sb, d};
		@(negedge mclk);
		// the answer stands only between the taking edge and the next one
		od_req.valid = 1'b0;
		chk(od_rsp.valid, 1);
		rv = od_rsp.rdata;
		er = od_rsp.error;
	endtask : acc
	task run(input logic post);
		@(negedge mclk);
		{post_run, pre_run} = {post, !post};
		@(negedge mclk);
		{post_run, pre_run} = 2'b00;
		chk(cib | cob, 1);
		chk(xs, 32'h0000_0000);
		chk(xm, MAP_RESET);
		i = 0;
		while ((cib || cob) && i < 400) begin
			@(posedge mclk);
			i++;
		end
		#1;
		// both tables of the phase pass through, the shared one included
		chk(post ? n_out : n_in, 32);
	endtask : run
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_presets;
		for (int t = 0; t < 3; t++) begin
			acc(0, IDX_IN_SEL + 16'(t * 16), 0, 0);
			chk(rv, 32'h0000_0010);
			acc(1, IDX_IN_SEL + 16'(t * 16), 8'h10, 32'h0000_1234);
			chk(er, 1);
			acc(0, IDX_IN_SEL + 16'(t * 16), 8'h10, 0);
			chk(rv, MAP_RESET);
		end
		acc(0, IDX_INPUTS, 0, 0);
		chk(rv, 32'h0000_0020);
		for (int s = 1; s <= 32; s++) begin
			acc(0, IDX_INPUTS, 8'(s), 0);
			chk(rv, INPUT_RESET);
		end
	endtask : t_presets
	task t_inputs;
		acc(1, IDX_INPUTS, 8'h01, 32'h8000_0001);
		acc(1, IDX_INPUTS, 8'h20, 32'hffff_fffe);
		acc(0, IDX_INPUTS, 8'h01, 0);
		chk(rv, 32'h8000_0001);
		acc(0, IDX_INPUTS, 8'h20, 0);
		chk(rv, 32'hffff_fffe);
		acc(1, IDX_INPUTS, 8'h00, 32'h0000_0005);
		chk(er, 1);
		acc(0, IDX_INPUTS, 8'h21, 0);
		chk(er, 1);
	endtask : t_inputs
	task t_uptime;
		logic [31:0] u0;
		acc(1, IDX_UPTIME, 0, 32'h0000_0099);
		chk(er, 1);
		u0 = up;
		i = 0;
		while (up === u0 && i < 20) begin
			@(posedge mclk);
			i++;
		end
		#1;
		u0 = up;
		repeat (30) @(posedge mclk);
		#1;
		chk(up, u0 + 3);
		acc(0, IDX_UPTIME, 0, 0);
		chk(rv, u0 + 32'h0000_0003);
		// mid-run reset: held over three edges so the step check sees a clean restart
		reset_n = 1'b0;
		repeat (3) @(negedge mclk);
		chk(up, UPTIME_RESET);
		reset_n = 1'b1;
		repeat (10) @(negedge mclk);
		chk(up, 32'h0000_0001);
	endtask : t_uptime
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		mclk = 0;
		forever #20 mclk = !mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results;
		end
	end
	initial begin
		{reset_n, pre_run, post_run, slow} = 4'b0001;
		od_req = '0;
		repeat (12) @(negedge mclk);
		chk(up, UPTIME_RESET);
		reset_n = 1;
		t_presets;
		t_inputs;
		run(0);
		slow = 0;
		run(1);
		t_uptime;
		results;
	end
endmodule : user_program_io_mapping_objects_test
